// file: inc/ssr_defs.vh
// Constants for the set/read command handler: frame layout, command codes,
// parameter store geometry and status-register layout.
// Assumes inclusion by bare name from the design files.
`ifndef SSR_DEFS_VH
`define SSR_DEFS_VH

// ----------------------------------------------------------------------
// Command frame byte 0 bit positions
// ----------------------------------------------------------------------
`define SSR_B0_START      0
`define SSR_B0_SERVO      1
`define SSR_B0_HALT       4
`define SSR_B0_FAULT_RST  5
`define SSR_B0_TYPE       7

// ----------------------------------------------------------------------
// Response byte 0 bit positions
// ----------------------------------------------------------------------
`define SSR_R0_START      0
`define SSR_R0_SERVO      1
`define SSR_R0_WARN       2
`define SSR_R0_ALARM      3
`define SSR_R0_HALT       4
`define SSR_R0_POWER      5
`define SSR_R0_READY      6
`define SSR_R0_ONE        7

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define SSR_CMD_NOP       4'h0
`define SSR_CMD_PREAD     4'h8
`define SSR_CMD_PWRITE    4'h9
`define SSR_CMD_POSSET    4'hA
`define SSR_CMD_ORIGIN    4'hB

// ----------------------------------------------------------------------
// Parameter store
// ----------------------------------------------------------------------
`define SSR_PAR_DEPTH     64
`define SSR_PAR_AW        6
`define SSR_PAR_OFFSET    16'h0809
`define SSR_PAR_LIMIT     32'h7FFFFFFF

// ----------------------------------------------------------------------
// Software registers (index on the plain register port)
// ----------------------------------------------------------------------
`define SSR_REG_STATUS    4'h0
`define SSR_REG_ENABLE    4'h1
`define SSR_REG_CLEAR     4'h2
`define SSR_REG_POS       4'h3
`define SSR_REG_OFFSET    4'h4
`define SSR_REG_CTRL      4'h5
`define SSR_REG_LAST      4'h6

// Status event bits
`define SSR_EV_DONE       0
`define SSR_EV_WARN       1
`define SSR_EV_ORIGIN     2
`define SSR_EV_REFUSED    3
`define SSR_EV_W          4

`endif

// file: src/ssr_event_bit.v
// One sticky event bit with enable gate: set by hardware, cleared by software.
// Assumes the clear strobe is one cycle; a set in the same cycle wins.
`timescale 1ns/1ps

module ssr_event_bit (
    clk,
    rst,
    ce,
    set_pulse,
    clr_pulse,
    enable,
    flag_r,
    irq_term
);
    input  wire clk;          // System clock
    input  wire rst;          // Synchronous reset
    input  wire ce;           // Clock enable
    input  wire set_pulse;    // Hardware event
    input  wire clr_pulse;    // Software clear
    input  wire enable;       // Interrupt enable
    output reg  flag_r;       // Sticky status
    output wire irq_term;     // Gated contribution

    // ------------------------------------------------------------------
    // Sticky flag, set over clear
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            flag_r <= 1'b0;
        end else if (ce) begin
            if (set_pulse) begin
                flag_r <= 1'b1;
            end else if (clr_pulse) begin
                flag_r <= 1'b0;
            end
        end
    end

    assign irq_term = flag_r & enable;
endmodule // ssr_event_bit

// file: src/ssr_cmd_handler.v
// Set/read command interpreter for a servo option unit on cyclic remote I/O.
// Assumes frames are presented as 8 parallel bytes synchronous to clk, and
// software uses a plain register port with read data one cycle later.
//
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`include "ssr_defs.vh"

module ssr_cmd_handler (
    clk,
    rst,
    ce,
    cmd_b0, cmd_b1, cmd_b2, cmd_b3, cmd_b4, cmd_b5, cmd_b6, cmd_b7,
    abs_encoder,
    unit_ready,
    power_on_flag,
    alarm_flag,
    motor_pos,
    reg_addr,
    reg_wdata,
    reg_wr,
    reg_rd,
    reg_rdata_r,
    rsp_b0_r, rsp_b1_r, rsp_b2_r, rsp_b3_r, rsp_b4_r, rsp_b5_r, rsp_b6_r, rsp_b7_r,
    pos_load_r,
    pos_value_r,
    irq_r
);
    input  wire        clk;            // 10 MHz clock
    input  wire        rst;            // Synchronous reset, high
    input  wire        ce;             // Clock enable
    input  wire [7:0]  cmd_b0;         // Command frame bytes
    input  wire [7:0]  cmd_b1;
    input  wire [7:0]  cmd_b2;
    input  wire [7:0]  cmd_b3;
    input  wire [7:0]  cmd_b4;
    input  wire [7:0]  cmd_b5;
    input  wire [7:0]  cmd_b6;
    input  wire [7:0]  cmd_b7;
    input  wire        abs_encoder;    // High when absolute encoder fitted
    input  wire        unit_ready;     // Unit ready level
    input  wire        power_on_flag;  // Main power present
    input  wire        alarm_flag;     // Drive alarm level
    input  wire [31:0] motor_pos;      // Present motor position
    input  wire [3:0]  reg_addr;       // Register index
    input  wire [31:0] reg_wdata;      // Register write data
    input  wire        reg_wr;         // Write strobe
    input  wire        reg_rd;         // Read strobe
    output reg  [31:0] reg_rdata_r;    // Read data, cycle after strobe
    output reg  [7:0]  rsp_b0_r;       // Response frame bytes
    output reg  [7:0]  rsp_b1_r;
    output reg  [7:0]  rsp_b2_r;
    output reg  [7:0]  rsp_b3_r;
    output reg  [7:0]  rsp_b4_r;
    output reg  [7:0]  rsp_b5_r;
    output reg  [7:0]  rsp_b6_r;
    output reg  [7:0]  rsp_b7_r;
    output reg         pos_load_r;     // One-cycle present-position load
    output reg  [31:0] pos_value_r;    // Value to load
    output reg         irq_r;          // Level interrupt

    // ------------------------------------------------------------------
    // Frame field decode
    // ------------------------------------------------------------------
    wire        set_read_frame = cmd_b0[`SSR_B0_TYPE];
    wire [3:0]  cmd_code       = cmd_b1[3:0];
    wire [15:0] cmd_num        = {cmd_b3, cmd_b2};
    wire [31:0] cmd_data       = {cmd_b7, cmd_b6, cmd_b5, cmd_b4};
    wire        start_lvl      = cmd_b0[`SSR_B0_START];

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    reg [31:0] par_mem [0:`SSR_PAR_DEPTH-1]; // Parameter store
    reg        start_prev_r;                 // Start bit from last cycle
    reg        start_echo_r;                 // Start echo held for response
    reg        warn_r;                       // Setting warning
    reg [31:0] offset_r;                     // Origin offset parameter
    reg        allow_origin_r;               // Software origin permit
    reg [7:0]  last_code_r;                  // Last executed code
    reg [3:0]  ev_clr;                       // Clear pulses
    reg [3:0]  ev_en_r;                      // Interrupt enables
    reg [3:0]  ev_set;                       // Event pulses
    wire [3:0] ev_flag;                      // Sticky flags
    wire [3:0] ev_term;                      // Gated flags

    // A command is taken only on a 0-to-1 start edge inside a set/read frame;
    // start held high repeats it only after the type bit drops and rises again, so the host must drop start or the type bit first.
    wire start_rise = set_read_frame & start_lvl & ~start_prev_r;
    wire num_valid  = (cmd_num[15:`SSR_PAR_AW] == 10'h000) || (cmd_num == `SSR_PAR_OFFSET);
    wire [`SSR_PAR_AW-1:0] par_idx = cmd_num[`SSR_PAR_AW-1:0];
    wire val_ok     = (cmd_data <= `SSR_PAR_LIMIT);
    wire is_offset  = (cmd_num == `SSR_PAR_OFFSET);

    // ------------------------------------------------------------------
    // Event bits: done, warning, origin set, origin refused
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `SSR_EV_W; gi = gi + 1) begin : g_ev
            ssr_event_bit u_ev (
                .clk       (clk),
                .rst       (rst),
                .ce        (ce),
                .set_pulse (ev_set[gi]),
                .clr_pulse (ev_clr[gi]),
                .enable    (ev_en_r[gi]),
                .flag_r    (ev_flag[gi]),
                .irq_term  (ev_term[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Event pulses from command execution
    // ------------------------------------------------------------------
    always @* begin
        ev_set = 4'h0;
        if (start_rise) begin
            ev_set[`SSR_EV_DONE] = 1'b1;
            if ((cmd_code == `SSR_CMD_PREAD || cmd_code == `SSR_CMD_PWRITE) && !num_valid) begin
                ev_set[`SSR_EV_WARN] = 1'b1;
            end
            if (cmd_code == `SSR_CMD_PWRITE && !val_ok) begin
                ev_set[`SSR_EV_WARN] = 1'b1;
            end
            if (cmd_code == `SSR_CMD_ORIGIN) begin
                if (abs_encoder && allow_origin_r) begin
                    ev_set[`SSR_EV_ORIGIN] = 1'b1;
                end else begin
                    // Incremental encoder or withdrawn permit: offset untouched
                    ev_set[`SSR_EV_REFUSED] = 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Software clear pulses
    // ------------------------------------------------------------------
    always @* begin
        // A clear that meets an event in one cycle loses: the flag keeps the set
        ev_clr = 4'h0;
        if (reg_wr && reg_addr == `SSR_REG_CLEAR) begin
            ev_clr = reg_wdata[3:0];
        end
    end

    // ------------------------------------------------------------------
    // Command execution and response frame
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            start_prev_r <= 1'b0;
            start_echo_r <= 1'b0;
            warn_r       <= 1'b0;
            offset_r     <= 32'h00000000;
            last_code_r  <= 8'h00;
            pos_load_r   <= 1'b0;
            pos_value_r  <= 32'h00000000;
            rsp_b1_r     <= 8'h00;
            rsp_b2_r     <= 8'h00;
            rsp_b3_r     <= 8'h00;
            rsp_b4_r     <= 8'h00;
            rsp_b5_r     <= 8'h00;
            rsp_b6_r     <= 8'h00;
            rsp_b7_r     <= 8'h00;
        end else if (ce) begin
            start_prev_r <= set_read_frame & start_lvl;
            start_echo_r <= start_lvl;
            pos_load_r   <= 1'b0;
            if (start_rise) begin
                rsp_b1_r    <= {4'h0, cmd_code};
                last_code_r <= {4'h0, cmd_code};
                // Each new command starts with the warning cleared
                warn_r      <= 1'b0;
                case (cmd_code)
                    `SSR_CMD_PREAD: begin
                        // Echo number, return stored value
                        {rsp_b3_r, rsp_b2_r} <= cmd_num;
                        if (is_offset) begin
                            {rsp_b7_r, rsp_b6_r, rsp_b5_r, rsp_b4_r} <= offset_r;
                        end else if (num_valid) begin
                            {rsp_b7_r, rsp_b6_r, rsp_b5_r, rsp_b4_r} <= par_mem[par_idx];
                        end else begin
                            {rsp_b7_r, rsp_b6_r, rsp_b5_r, rsp_b4_r} <= 32'h00000000;
                            warn_r <= 1'b1;
                        end
                    end
                    `SSR_CMD_PWRITE: begin
                        // Store value when number and range are good
                        {rsp_b3_r, rsp_b2_r} <= cmd_num;
                        {rsp_b7_r, rsp_b6_r, rsp_b5_r, rsp_b4_r} <= cmd_data;
                        if (!num_valid || !val_ok) begin
                            warn_r <= 1'b1;
                        end else if (is_offset) begin
                            offset_r <= cmd_data;
                        end
                    end
                    `SSR_CMD_POSSET: begin
                        // Replace present position
                        pos_load_r  <= 1'b1;
                        pos_value_r <= cmd_data;
                        {rsp_b3_r, rsp_b2_r} <= 16'h0000;
                        {rsp_b7_r, rsp_b6_r, rsp_b5_r, rsp_b4_r} <= cmd_data;
                    end
                    `SSR_CMD_ORIGIN: begin
                        // Data fields ignored, answer zero
                        {rsp_b3_r, rsp_b2_r} <= 16'h0000;
                        {rsp_b7_r, rsp_b6_r, rsp_b5_r, rsp_b4_r} <= 32'h00000000;
                        if (abs_encoder && allow_origin_r) begin
                            // Offset that makes the present position read as zero
                            offset_r <= 32'h00000000 - motor_pos;
                        end
                    end
                    default: begin
                        // No-operation and unhandled codes
                        {rsp_b3_r, rsp_b2_r} <= 16'h0000;
                        {rsp_b7_r, rsp_b6_r, rsp_b5_r, rsp_b4_r} <= 32'h00000000;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Parameter store write port (no reset on array)
    // Contents are undefined until written, so software loads a word
    // before reading it back; the offset parameter lives in offset_r.
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (ce && start_rise && cmd_code == `SSR_CMD_PWRITE && num_valid && val_ok && !is_offset) begin
            par_mem[par_idx] <= cmd_data;
        end
    end

    // ------------------------------------------------------------------
    // Response status byte, interrupt output
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            rsp_b0_r <= 8'h80;
            irq_r    <= 1'b0;
        end else if (ce) begin
            // Warning and start echo pass through warn_r and start_echo_r,
            // so they show one edge after the edge that takes the start.
            rsp_b0_r[`SSR_R0_ONE]   <= 1'b1;
            rsp_b0_r[`SSR_R0_READY] <= unit_ready;
            rsp_b0_r[`SSR_R0_POWER] <= power_on_flag;
            rsp_b0_r[`SSR_R0_HALT]  <= cmd_b0[`SSR_B0_HALT];
            rsp_b0_r[`SSR_R0_ALARM] <= alarm_flag;
            rsp_b0_r[`SSR_R0_WARN]  <= warn_r;
            rsp_b0_r[`SSR_R0_SERVO] <= cmd_b0[`SSR_B0_SERVO];
            rsp_b0_r[`SSR_R0_START] <= start_echo_r;
            // Registered: the line follows an enabled flag one edge later
            irq_r <= |ev_term;
        end
    end

    // ------------------------------------------------------------------
    // Software registers: enable, control, read data
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            ev_en_r        <= 4'h0;
            allow_origin_r <= 1'b1;
            reg_rdata_r    <= 32'h00000000;
        end else if (ce) begin
            if (reg_wr && reg_addr == `SSR_REG_ENABLE) begin
                ev_en_r <= reg_wdata[3:0];
            end
            if (reg_wr && reg_addr == `SSR_REG_CTRL) begin
                allow_origin_r <= reg_wdata[0];
            end
            // Zero outside the cycle after a read strobe, so a stray sample
            // of the port never returns stale register contents.
            reg_rdata_r <= 32'h00000000;
            if (reg_rd) begin
                case (reg_addr)
                    `SSR_REG_STATUS: reg_rdata_r <= {28'h0000000, ev_flag};
                    `SSR_REG_ENABLE: reg_rdata_r <= {28'h0000000, ev_en_r};
                    `SSR_REG_POS:    reg_rdata_r <= pos_value_r;
                    `SSR_REG_OFFSET: reg_rdata_r <= offset_r;
                    `SSR_REG_CTRL:   reg_rdata_r <= {31'h00000000, allow_origin_r};
                    `SSR_REG_LAST:   reg_rdata_r <= {24'h000000, last_code_r};
                    default:         reg_rdata_r <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // ssr_cmd_handler

// file: verification/ssr_cmd_handler_chk.sv
// Concurrent checks on the set/read command handler ports.
// Assumes binding to ssr_cmd_handler; sees its ports only.
`timescale 1ns/1ps
`include "ssr_defs.vh"

module ssr_cmd_handler_chk (
    input wire        clk,
    input wire        rst,
    input wire        ce,
    input wire [7:0]  cmd_b0, cmd_b1, cmd_b2, cmd_b3, cmd_b4, cmd_b5, cmd_b6, cmd_b7,
    input wire        reg_rd,
    input wire [31:0] reg_rdata_r,
    input wire [7:0]  rsp_b0_r, rsp_b1_r, rsp_b2_r, rsp_b3_r, rsp_b4_r, rsp_b5_r, rsp_b6_r, rsp_b7_r,
    input wire        pos_load_r,
    input wire [31:0] pos_value_r
);
    // ------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------
    reg         start_prev_r;                                  // Start bit at last edge
    wire        accept   = ce && !rst && cmd_b0[7] && cmd_b0[0] && !start_prev_r; // Command taken
    wire [3:0]  code     = cmd_b1[3:0];                        // Command code
    wire [15:0] num      = {cmd_b3, cmd_b2};                   // Command number
    wire [31:0] cmd_data = {cmd_b7, cmd_b6, cmd_b5, cmd_b4};   // Command data
    wire [31:0] rsp_data = {rsp_b7_r, rsp_b6_r, rsp_b5_r, rsp_b4_r};
    wire [15:0] rsp_num  = {rsp_b3_r, rsp_b2_r};
    wire [55:0] rsp_all  = {rsp_data, rsp_num, rsp_b1_r};      // Bytes 1..7

    // Tracks the start bit so a rising start can be recognised
    always @(posedge clk) begin
        if (rst) begin
            start_prev_r <= 1'b0;
        end else if (ce) begin
            start_prev_r <= cmd_b0[7] & cmd_b0[0];
        end
    end

    default clocking dc @(posedge clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    marker_bit_a: assert property (rsp_b0_r[7])
        else $error("response byte 0 bit 7 low");
    code_echo_a: assert property (accept |=> rsp_b1_r == {4'h0, $past(code)})
        else $error("command code not echoed");
    read_number_a: assert property (accept && code == `SSR_CMD_PREAD |=> rsp_num == $past(num))
        else $error("read number not echoed");
    write_echo_a: assert property (accept && code == `SSR_CMD_PWRITE && !cmd_b7[7] && num < 16'h0040
        |=> rsp_num == $past(num) && rsp_data == $past(cmd_data)) else $error("write echo wrong");
    origin_zero_a: assert property (accept && code == `SSR_CMD_ORIGIN |=> rsp_all[55:8] == 48'h0)
        else $error("origin response not zero");
    pos_set_a: assert property (accept && code == `SSR_CMD_POSSET
        |=> pos_load_r && pos_value_r == $past(cmd_data) && rsp_data == $past(cmd_data) && rsp_num == 16'h0)
        else $error("position set not applied");
    load_cause_a: assert property (pos_load_r |-> $past(accept) && rsp_b1_r == {4'h0, `SSR_CMD_POSSET})
        else $error("position load without command");
    frame_hold_a: assert property (!accept && !rst |=> $stable(rsp_all))
        else $error("response changed without command");
    bad_number_a: assert property (accept && code == `SSR_CMD_PREAD && num > 16'h003F
        && num != `SSR_PAR_OFFSET |-> ##2 rsp_b0_r[2]) else $error("no warning on bad number");
    start_echo_a: assert property (cmd_b0[7] && $past(cmd_b0[7]) |-> ##2 rsp_b0_r[0] == $past(cmd_b0[0], 2))
        else $error("start echo wrong");
    read_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_r == 32'h0)
        else $error("read data outside read cycle");
endmodule // ssr_cmd_handler_chk

bind ssr_cmd_handler ssr_cmd_handler_chk i_ssr_cmd_handler_chk (.clk, .rst, .ce, .cmd_b0, .cmd_b1, .cmd_b2,
    .cmd_b3, .cmd_b4, .cmd_b5, .cmd_b6, .cmd_b7, .reg_rd, .reg_rdata_r, .rsp_b0_r, .rsp_b1_r, .rsp_b2_r,
    .rsp_b3_r, .rsp_b4_r, .rsp_b5_r, .rsp_b6_r, .rsp_b7_r, .pos_load_r, .pos_value_r);

// file: verification/ssr_host_model.sv
// Host controller model: drives set/read command frames to the unit.
// Assumes one clock shared with the unit; the frame changes after rising edges.
`timescale 1ns/1ps

module ssr_host_model (
    input  wire        clk,     // Shared clock
    output reg  [63:0] frame    // Bytes 0..7, byte 0 lowest
);
    // ------------------------------------------------------------
    // Idle frame: set/read type, start low
    // ------------------------------------------------------------
    initial frame = 64'h80;

    // Operands and a rising start together, then start drops and the answer settles
    task issue(input [7:0] base, input [3:0] code, input [15:0] num, input [31:0] data);
        begin
            @(posedge clk);
            frame <= {data, num, 4'h0, code, base | 8'h01};
            @(posedge clk);
            frame[0] <= 1'b0;
            repeat (2) @(posedge clk);
            #1;
        end
    endtask
endmodule // ssr_host_model

// file: verification/servo_set_read_command_handler_tb.sv
// Testbench for the set/read command handler.
// Assumes the host model drives frames; the bench owns the register port.
`timescale 1ns/1ps

module servo_set_read_command_handler_tb;
    reg         clk = 1'b0;     // 10 MHz clock
    reg         rst = 1'b1;     // Synchronous reset
    reg         abs_enc = 1'b1; // Encoder kind
    reg         rdy = 1'b0;     // Drive status levels
    reg         pwr = 1'b0;
    reg         alm = 1'b0;
    reg  [31:0] mpos = 32'h0;   // Present motor position
    reg  [3:0]  addr = 4'h0;    // Register port
    reg  [31:0] wdata = 32'h0;
    reg         wr = 1'b0;
    reg         rd = 1'b0;
    wire [63:0] frame;          // Command frame
    wire [31:0] rdata, pos_val;
    wire [7:0]  r0, r1, r2, r3, r4, r5, r6, r7;
    wire        pos_load, irq;
    integer     fails = 0, check_count = 0, loads = 0;

    ssr_host_model i_ssr_host_model (.clk(clk), .frame(frame));
    ssr_cmd_handler i_ssr_cmd_handler (.clk(clk), .rst(rst), .ce(1'b1),
        .cmd_b0(frame[7:0]), .cmd_b1(frame[15:8]), .cmd_b2(frame[23:16]), .cmd_b3(frame[31:24]),
        .cmd_b4(frame[39:32]), .cmd_b5(frame[47:40]), .cmd_b6(frame[55:48]), .cmd_b7(frame[63:56]),
        .abs_encoder(abs_enc), .unit_ready(rdy), .power_on_flag(pwr), .alarm_flag(alm), .motor_pos(mpos),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata_r(rdata),
        .rsp_b0_r(r0), .rsp_b1_r(r1), .rsp_b2_r(r2), .rsp_b3_r(r3), .rsp_b4_r(r4), .rsp_b5_r(r5),
        .rsp_b6_r(r6), .rsp_b7_r(r7), .pos_load_r(pos_load), .pos_value_r(pos_val), .irq_r(irq));

    // ------------------------------------------------------------
    // Clock, load counter, watchdog
    // ------------------------------------------------------------
    initial forever #50 clk = ~clk;
    always @(posedge clk) if (pos_load === 1'b1) loads <= loads + 1;
    initial begin
        #2000000;
        fails = fails + 1;
        complete_run;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task chk(input [63:0] got, input [63:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task reg_write(input [3:0] a, input [31:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
        end
    endtask
    task reg_read(input [3:0] a, input [31:0] exp);
        begin
            @(posedge clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1 chk(rdata, exp);
        end
    endtask
    // One command and a check of the whole response frame
    task cmd(input [7:0] b, input [3:0] c, input [15:0] n, input [31:0] d, input [63:0] exp);
        begin
            i_ssr_host_model.issue(b, c, n, d);
            chk({r7, r6, r5, r4, r3, r2, r1, r0}, exp);
        end
    endtask
    task complete_run;
        begin
            $display("checks %0d mismatches %0d", check_count, fails);
            if (fails == 0 && check_count > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        #1 chk({r7, r6, r5, r4, r3, r2, r1, r0}, 64'h80);
        reg_read(4'h0, 32'h0);
        reg_read(4'h1, 32'h0);
        reg_read(4'h5, 32'h1);
        reg_read(4'h4, 32'h0);
        reg_write(4'hF, 32'hFFFFFFFF);
        reg_read(4'hF, 32'h0);
        $display("test reset done");
        cmd(8'h80, 4'h9, 16'h0005, 32'h12345678, {32'h12345678, 16'h0005, 16'h0980});
        cmd(8'h80, 4'h8, 16'h0005, 32'h0, {32'h12345678, 16'h0005, 16'h0880});
        cmd(8'h80, 4'h9, 16'h003F, 32'h7FFFFFFF, {32'h7FFFFFFF, 16'h003F, 16'h0980});
        i_ssr_host_model.issue(8'h80, 4'h9, 16'h003F, 32'h80000000);
        chk(r0, 8'h84);
        cmd(8'h80, 4'h8, 16'h003F, 32'h0, {32'h7FFFFFFF, 16'h003F, 16'h0880});
        i_ssr_host_model.issue(8'h80, 4'h8, 16'h0040, 32'h0);
        chk({r1, r0}, 16'h0884);
        reg_read(4'h0, 32'h3);
        $display("test parameters done");
        cmd(8'h80, 4'hA, 16'h1234, 32'hFFFFFF9C, {32'hFFFFFF9C, 16'h0000, 16'h0A80});
        chk(pos_val, 32'hFFFFFF9C);
        chk(loads, 1);
        reg_read(4'h3, 32'hFFFFFF9C);
        reg_read(4'h6, 32'h0000000A);
        $display("test position done");
        @(posedge clk) mpos <= 32'h00000100;
        cmd(8'h80, 4'hB, 16'hABCD, 32'h55AA55AA, {48'h0, 16'h0B80});
        reg_read(4'h4, 32'hFFFFFF00);
        reg_read(4'h0, 32'h7);
        cmd(8'h80, 4'h8, 16'h0809, 32'h0, {32'hFFFFFF00, 16'h0809, 16'h0880});
        i_ssr_host_model.issue(8'h80, 4'hE, 16'h0, 32'h0);
        $display("test origin done");
        reg_write(4'h1, 32'h8);
        reg_write(4'h2, 32'hF);
        cmd(8'h80, 4'h8, 16'h0005, 32'h0, {32'h12345678, 16'h0005, 16'h0880});
        chk(irq, 1'b0);
        @(posedge clk);
        abs_enc <= 1'b0;
        mpos <= 32'h00000200;
        cmd(8'h80, 4'hB, 16'h0, 32'h0, {48'h0, 16'h0B80});
        chk(irq, 1'b1);
        reg_read(4'h4, 32'hFFFFFF00);
        reg_write(4'h2, 32'h8);
        repeat (2) @(posedge clk);
        #1 chk(irq, 1'b0);
        reg_write(4'h5, 32'h0);
        abs_enc <= 1'b1;
        i_ssr_host_model.issue(8'h80, 4'hB, 16'h0, 32'h0);
        chk(irq, 1'b1);
        reg_read(4'h4, 32'hFFFFFF00);
        $display("test refusal done");
        @(posedge clk);
        rdy <= 1'b1;
        pwr <= 1'b1;
        alm <= 1'b1;
        cmd(8'h92, 4'h8, 16'h0005, 32'h0, {32'h12345678, 16'h0005, 16'h08FA});
        cmd(8'h00, 4'h9, 16'h0005, 32'hDEADBEEF, {32'h12345678, 16'h0005, 16'h08E8});
        cmd(8'h80, 4'h8, 16'h0005, 32'h0, {32'h12345678, 16'h0005, 16'h08E8});
        $display("test status done");
        @(posedge clk) rst <= 1'b1;
        @(posedge clk) rst <= 1'b0;
        reg_read(4'h4, 32'h0);
        reg_read(4'h5, 32'h1);
        reg_read(4'h1, 32'h0);
        $display("test second reset done");
        complete_run;
    end
endmodule // servo_set_read_command_handler_tb
